// file: hw/rgb_host_end.sv
// host end of the rgb link: pixel clock divider, sync generator, panel reset
// assumes the user supplies pixel data in the cycle it is requested
// Summary of operation
// RULE1 - line lasts 862 to 1200 pixel clocks
// RULE2 - exactly 800 active pixels per line
// RULE3 - hsync high for 1 to 40 clocks
// RULE4 - back porch 46, front porch 16 to 354
// RULE5 - exactly 480 active lines per frame
// RULE6 - frame lasts 510 to 650 lines
// RULE7 - vsync 1-20 lines, porches 23 and 7-147
// RULE8 - pixel clock at most 50 MHz
// RULE9 - 24-bit bus sampled on pixel clock edge
// RULE10 - mode high: window from data-enable strobe
// RULE11 - mode low: window from syncs and porches
// RULE12 - source outputs update 20 clocks after hsync
// RULE13 - source latch at 20, 10 clocks wide
// RULE14 - gate start 2 clocks after hsync
// RULE15 - gate shift clock at 20, 66 wide
// RULE16 - gate output enable at 4, 74 wide
// RULE17 - panel reset held low at least 10 us
// RULE18 - porch counted from sync leading edge
`default_nettype none
`include "rgb_params.svh"
module rgb_host_end
	import rgb_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_run,
	input wire rgb_lane_t i_pix_a,
	input wire rgb_lane_t i_pix_b,
	input wire rgb_lane_t i_pix_c,
	output logic o_pixel_req,
	output logic o_frame_start,
	output logic o_busy,
	rgb_link_if.host link
);
	// pixel clock is the system clock divided by two: 50 MHz, 50 % duty
	logic pclk_q;
	rgb_host_state_t state_q;
	rgb_host_state_t state_d;
	logic [9:0] rst_cnt_q;
	logic panel_rst_n_q;
	rgb_hcnt_t h_q;
	rgb_vcnt_t v_q;
	logic hs_q;
	logic vs_q;
	logic de_q;
	logic fs_q;
	rgb_lane_t pa_q;
	rgb_lane_t pb_q;
	rgb_lane_t pc_q;

	// tick marks the cycle before the pixel clock falls; outputs change
	// with the fall so they sit a whole half period before the rise
	wire tick = pclk_q; // RULE9

	// state decode
	wire in_rst = (state_q == RGB_ST_PANEL_RST);
	wire in_scan = (state_q == RGB_ST_SCAN);
	wire rst_done = (rst_cnt_q == 10'(`RGB_RST_CYCLES - 1)); // RULE17

	// next raster position; the counters wrap at the fixed totals
	wire h_last = (h_q == `RGB_H_TOTAL - 11'h001); // RULE1
	wire v_last = (v_q == `RGB_V_TOTAL - 10'h001); // RULE6
	wire frame_end = h_last & v_last;
	wire rgb_hcnt_t h_nxt = h_last ? 11'h000 : h_q + 11'h001;
	wire rgb_vcnt_t v_nxt = !h_last ? v_q : v_last ? 10'h000 : v_q + 10'h001;

	// sync pulses start at count zero of their period
	wire hs_nxt = (h_nxt < `RGB_H_SYNC); // RULE3
	wire vs_nxt = (v_nxt < `RGB_V_SYNC); // RULE7

	// active window opens a fixed back porch after the sync leading edge;
	// the rest of the period is front porch (210 clocks, 22 lines)
	wire h_act = (h_nxt >= `RGB_H_BACK) && (h_nxt < `RGB_H_ACT_END); // RULE4 RULE2
	wire v_act = (v_nxt >= `RGB_V_BACK) && (v_nxt < `RGB_V_ACT_END); // RULE7 RULE5
	wire act_nxt = h_act & v_act;
	wire adv = in_scan & tick;

	// state flow: panel reset pulse, wait for run, scan whole frames
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			RGB_ST_PANEL_RST:
			begin
				if (rst_done)
				begin
					state_d = RGB_ST_IDLE;
				end
			end
			RGB_ST_IDLE:
			begin
				// start on a tick so the first pixel period is a full one
				if (i_run && tick)
				begin
					state_d = RGB_ST_SCAN;
				end
			end
			RGB_ST_SCAN:
			begin
				// a stop request only takes effect at a frame boundary
				if (adv && frame_end && !i_run)
				begin
					state_d = RGB_ST_IDLE;
				end
			end
			default:
			begin
				state_d = RGB_ST_PANEL_RST;
			end
		endcase
	end

	// divider and state; the divider never stops, the panel sees it always
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pclk_q <= 1'b0;
			state_q <= RGB_ST_PANEL_RST;
		end
		else
		begin
			pclk_q <= ~pclk_q; // RULE8
			state_q <= state_d;
		end
	end

	// panel reset pulse: low from our reset until the count expires
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rst_cnt_q <= 10'h000;
			panel_rst_n_q <= 1'b0;
		end
		else
		begin
			if (in_rst && !rst_done)
			begin
				rst_cnt_q <= rst_cnt_q + 10'h001;
			end
			panel_rst_n_q <= !in_rst || rst_done; // RULE17
		end
	end

	// raster counters park at the last position so the first tick of a
	// scan lands on line 0 pixel 0 with both syncs rising together
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			h_q <= `RGB_H_TOTAL - 11'h001;
			v_q <= `RGB_V_TOTAL - 10'h001;
		end
		else if (!in_scan)
		begin
			h_q <= `RGB_H_TOTAL - 11'h001;
			v_q <= `RGB_V_TOTAL - 10'h001;
		end
		else if (adv)
		begin
			h_q <= h_nxt; // RULE1
			v_q <= v_nxt; // RULE6
		end
	end

	// link outputs from flops; the strobe is driven in both panel modes,
	// a panel in sync mode simply ignores it
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			{hs_q, vs_q, de_q, fs_q} <= 4'h0;
		end
		else if (!in_scan)
		begin
			{hs_q, vs_q, de_q, fs_q} <= 4'h0;
		end
		else
		begin
			fs_q <= adv && (h_nxt == 11'h000) && (v_nxt == 10'h000);
			if (adv)
			begin
				hs_q <= hs_nxt; // RULE3
				vs_q <= vs_nxt; // RULE7
				de_q <= act_nxt; // RULE10
			end
		end
	end

	// pixel lanes: user data taken on request, zero outside the window
	// so porches never carry stale colour
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			{pa_q, pb_q, pc_q} <= 24'h000000;
		end
		else if (adv)
		begin
			pa_q <= act_nxt ? i_pix_a : 8'h00; // RULE9 RULE2
			pb_q <= act_nxt ? i_pix_b : 8'h00;
			pc_q <= act_nxt ? i_pix_c : 8'h00;
		end
	end

	// request is combinational so the user has the whole cycle to answer
	assign o_pixel_req = adv & act_nxt; // RULE2 RULE5
	assign o_frame_start = fs_q;
	assign o_busy = in_scan;

	// drive the link
	assign link.pixel_clock = pclk_q; // RULE8
	assign link.hsync_in = hs_q;
	assign link.vsync_in = vs_q;
	assign link.data_enable_strobe = de_q; // RULE10
	assign link.pixel_lane_a = pa_q;
	assign link.pixel_lane_b = pb_q;
	assign link.pixel_lane_c = pc_q;
	assign link.reset_n = panel_rst_n_q; // RULE17
endmodule // rgb_host_end
`default_nettype wire

// file: shared/rgb_params.svh
// constants for the parallel rgb link: host timing, panel pulse timing
// assumes a single 100 MHz system clock on both ends
`ifndef RGB_PARAMS_SVH
`define RGB_PARAMS_SVH

// system clock rate and panel reset pulse
`define RGB_CLK_MHZ 32'h64
`define RGB_RST_PULSE_NS 32'h2710
`define RGB_RST_CYCLES ((`RGB_RST_PULSE_NS * `RGB_CLK_MHZ + 32'h3E7) / 32'h3E8)

// horizontal timing in pixel clocks, counted from the hsync leading edge
`define RGB_H_TOTAL 11'h420
`define RGB_H_SYNC 11'h14
`define RGB_H_BACK 11'h2E
`define RGB_H_ACTIVE 11'h320
`define RGB_H_ACT_END 11'h34E

// vertical timing in lines, counted from the vsync leading edge
`define RGB_V_TOTAL 10'h20D
`define RGB_V_SYNC 10'h00A
`define RGB_V_BACK 10'h017
`define RGB_V_ACTIVE 10'h1E0
`define RGB_V_ACT_END 10'h1F7

// panel internal pulses, in pixel clocks after the hsync edge
`define RGB_SRC_UPD 11'h14
`define RGB_LD_START 11'h14
`define RGB_LD_END 11'h1E
`define RGB_STV_AT 11'h02
`define RGB_CKV_START 11'h14
`define RGB_CKV_END 11'h56
`define RGB_OEV_START 11'h04
`define RGB_OEV_END 11'h4E

`endif

// file: shared/rgb_pkg.sv
// types shared by both ends of the rgb link
// assumes nothing beyond the params header
`default_nettype none
package rgb_pkg;
	typedef logic [7:0] rgb_lane_t;
	typedef logic [10:0] rgb_hcnt_t;
	typedef logic [9:0] rgb_vcnt_t;
	typedef enum logic [1:0]
	{
		RGB_ST_PANEL_RST = 2'h0,
		RGB_ST_IDLE = 2'h1,
		RGB_ST_SCAN = 2'h2
	} rgb_host_state_t;
endpackage
`default_nettype wire

// file: shared/rgb_link_if.sv
// parallel rgb video link between host controller and panel
// all signals change on the shared system clock
`default_nettype none
interface rgb_link_if;
	import rgb_pkg::*;
	logic pixel_clock;
	logic hsync_in;
	logic vsync_in;
	logic data_enable_strobe;
	rgb_lane_t pixel_lane_a;
	rgb_lane_t pixel_lane_b;
	rgb_lane_t pixel_lane_c;
	logic reset_n;
	modport host
	(
		output pixel_clock, hsync_in, vsync_in, data_enable_strobe,
		output pixel_lane_a, pixel_lane_b, pixel_lane_c, reset_n
	);
	modport panel
	(
		input pixel_clock, hsync_in, vsync_in, data_enable_strobe,
		input pixel_lane_a, pixel_lane_b, pixel_lane_c, reset_n
	);
endinterface
`default_nettype wire

// file: hw/rgb_panel_end.sv
// panel end of the rgb link: samples pixels, makes source and gate pulses
// assumes the link is driven by logic on the same system clock
`default_nettype none
`include "rgb_params.svh"
module rgb_panel_end
	import rgb_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_mode_sel,
	rgb_link_if.panel link,
	output logic o_panel_ready,
	output logic o_pix_valid,
	output rgb_lane_t o_pix_a,
	output rgb_lane_t o_pix_b,
	output rgb_lane_t o_pix_c,
	output logic o_src_update,
	output logic o_source_latch_pulse,
	output logic o_gate_start_pulse,
	output logic o_gate_shift_clock,
	output logic o_gate_output_enable
);
	logic mode_s1_q, mode_s2_q, rst_s1_q, rst_s2_q;
	logic pclk_prev_q, hs_prev_q, vs_prev_q;
	rgb_hcnt_t h_q;
	rgb_vcnt_t v_q;
	logic valid_q, src_q, ld_q, stv_q, ckv_q, oev_q;
	rgb_lane_t pa_q, pb_q, pc_q;

	// mode strap and panel reset come from pins: two flops before use
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			{mode_s1_q, mode_s2_q, rst_s1_q, rst_s2_q} <= 4'h0;
		end
		else
		begin
			{mode_s1_q, rst_s1_q} <= {i_mode_sel, link.reset_n};
			{mode_s2_q, rst_s2_q} <= {mode_s1_q, rst_s1_q};
		end
	end

	// pixel clock rising edge and sync leading edges, counted in pixel clocks
	wire rise = link.pixel_clock & ~pclk_prev_q; // RULE9
	wire hs_edge = rise & link.hsync_in & ~hs_prev_q;
	wire vs_edge = rise & link.vsync_in & ~vs_prev_q;
	wire h_sat = &h_q;
	wire v_sat = &v_q;
	wire rgb_hcnt_t h_d = hs_edge ? 11'h000 : (rise && !h_sat) ? h_q + 11'h001 : h_q; // RULE18
	wire rgb_vcnt_t v_d = vs_edge ? 10'h000 : (hs_edge && !v_sat) ? v_q + 10'h001 : v_q; // RULE18

	// sync mode window: back porch from the sync leading edge, then 800 x 480
	wire h_win = (h_d >= `RGB_H_BACK) && (h_d < `RGB_H_ACT_END); // RULE11
	wire v_win = (v_d >= `RGB_V_BACK) && (v_d < `RGB_V_ACT_END); // RULE11
	// data-enable mode trusts the strobe alone
	wire act = mode_s2_q ? link.data_enable_strobe : (h_win & v_win); // RULE10

	// panel pulses as levels, re-evaluated on every pixel clock
	wire ld_d = (h_d >= `RGB_LD_START) && (h_d < `RGB_LD_END); // RULE13
	wire ckv_d = (h_d >= `RGB_CKV_START) && (h_d < `RGB_CKV_END); // RULE15
	wire oev_d = (h_d >= `RGB_OEV_START) && (h_d < `RGB_OEV_END); // RULE16
	// gate start only on the line that opens the frame
	wire stv_d = (h_d == `RGB_STV_AT) && (v_d == 10'h000); // RULE14

	// counters and edge history; panel reset holds everything at idle
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			{pclk_prev_q, hs_prev_q, vs_prev_q} <= 3'h0;
			h_q <= 11'h7FF;
			v_q <= 10'h3FF;
		end
		else if (!rst_s2_q)
		begin
			{pclk_prev_q, hs_prev_q, vs_prev_q} <= 3'h0;
			h_q <= 11'h7FF;
			v_q <= 10'h3FF;
		end
		else
		begin
			pclk_prev_q <= link.pixel_clock;
			if (rise)
			begin
				hs_prev_q <= link.hsync_in;
				vs_prev_q <= link.vsync_in;
			end
			h_q <= h_d;
			v_q <= v_d;
		end
	end

	// registered outputs; latch and gate pulses move only on pixel clock rises, source update lasts one system cycle
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			{valid_q, src_q, ld_q, stv_q, ckv_q, oev_q} <= 6'h00;
			{pa_q, pb_q, pc_q} <= 24'h000000;
		end
		else if (!rst_s2_q)
		begin
			{valid_q, src_q, ld_q, stv_q, ckv_q, oev_q} <= 6'h00;
			{pa_q, pb_q, pc_q} <= 24'h000000;
		end
		else
		begin
			valid_q <= rise & act;
			src_q <= rise && (h_d == `RGB_SRC_UPD); // RULE12
			if (rise)
			begin
				{ld_q, stv_q, ckv_q, oev_q} <= {ld_d, stv_d, ckv_d, oev_d};
			end
			if (rise & act)
			begin
				// all three lanes taken together on the same edge
				pa_q <= link.pixel_lane_a; // RULE9
				pb_q <= link.pixel_lane_b;
				pc_q <= link.pixel_lane_c;
			end
		end
	end

	assign o_panel_ready = rst_s2_q;
	assign o_pix_valid = valid_q;
	assign o_pix_a = pa_q;
	assign o_pix_b = pb_q;
	assign o_pix_c = pc_q;
	assign o_src_update = src_q;
	assign o_source_latch_pulse = ld_q;
	assign o_gate_start_pulse = stv_q;
	assign o_gate_shift_clock = ckv_q;
	assign o_gate_output_enable = oev_q;
endmodule // rgb_panel_end
`default_nettype wire

// file: verif/rgb_link_checker.sv
// checker for the rgb link: pixel clock, sync, enable and panel pulse timing
// assumes it sits beside the link in the bench, all on one system clock
`default_nettype none
module rgb_link_checker
	import rgb_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic pixel_clock,
	input wire logic hsync_in,
	input wire logic vsync_in,
	input wire logic data_enable_strobe,
	input wire rgb_lane_t pixel_lane_a,
	input wire rgb_lane_t pixel_lane_b,
	input wire rgb_lane_t pixel_lane_c,
	input wire logic o_src_update,
	input wire logic o_source_latch_pulse,
	input wire logic o_gate_start_pulse,
	input wire logic o_gate_shift_clock,
	input wire logic o_gate_output_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	logic hs_prev_q;
	logic seen_q;
	logic [15:0] lc_q;
	logic hs_rise;
	// line position in system cycles; two per pixel clock
	assign hs_rise = hsync_in && !hs_prev_q;
	// seen_q keeps the first line, timed from reset, out of the length check
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			hs_prev_q <= 1'b0;
			seen_q <= 1'b0;
			lc_q <= 16'h0;
		end
		else
		begin
			hs_prev_q <= hsync_in;
			seen_q <= seen_q | hs_rise;
			lc_q <= hs_rise ? 16'h1 : lc_q + 16'h1;
		end
	end
	sequence s_stv_pulse;
		o_gate_start_pulse [*2] ##1 !o_gate_start_pulse;
	endsequence
	a_pclk_toggle: assert property (1'b1 |=> pixel_clock != $past(pixel_clock))
		else $error("pixel clock did not toggle");
	a_link_stable: assert property ($rose(pixel_clock) |->
		$stable({hsync_in, vsync_in, data_enable_strobe, pixel_lane_a, pixel_lane_b, pixel_lane_c}))
		else $error("link changed across the pixel clock rise");
	a_line_length: assert property (hs_rise && seen_q |-> lc_q == 16'h840)
		else $error("line length wrong");
	a_hsync_width: assert property ($fell(hsync_in) |-> lc_q == 16'h28)
		else $error("hsync width wrong");
	a_de_start: assert property ($rose(data_enable_strobe) |-> lc_q == 16'h5C)
		else $error("back porch wrong");
	a_de_width: assert property ($fell(data_enable_strobe) |-> lc_q == 16'h69C)
		else $error("active width wrong");
	a_latch_window: assert property ($changed(o_source_latch_pulse) |->
		lc_q == (o_source_latch_pulse ? 16'h2A : 16'h3E))
		else $error("source latch timing wrong");
	a_shift_window: assert property ($changed(o_gate_shift_clock) |->
		lc_q == (o_gate_shift_clock ? 16'h2A : 16'hAE))
		else $error("gate shift timing wrong");
	a_oe_window: assert property ($changed(o_gate_output_enable) |->
		lc_q == (o_gate_output_enable ? 16'hA : 16'h9E))
		else $error("gate enable timing wrong");
	a_src_update: assert property ($rose(o_src_update) |-> lc_q == 16'h2A ##1 !o_src_update)
		else $error("source update timing wrong");
	a_gate_start: assert property ($rose(o_gate_start_pulse) |->
		lc_q == 16'h6 && vsync_in ##0 s_stv_pulse)
		else $error("gate start timing wrong");
endmodule // rgb_link_checker
`default_nettype wire

// file: verif/tb_top.sv
// bench: host and panel ends joined by the link, user side driven here
// assumes 100 MHz; a full frame is too long, so the run covers 26 lines
`default_nettype none
`define CHK(nm, ex, got) \
	begin \
		check_count++; \
		if ((got) !== (ex)) \
		begin \
			$display("wrong value %s exp %0h got %0h", nm, ex, got); \
			errors++; \
		end \
	end
module tb_top
	import rgb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk_sys;
	logic i_rst_n;
	logic i_run;
	logic i_mode_sel;
	rgb_lane_t i_pix_a = 8'h00;
	rgb_lane_t i_pix_b = 8'h00;
	rgb_lane_t i_pix_c = 8'h00;
	logic o_pixel_req;
	logic o_frame_start;
	logic o_busy;
	logic o_panel_ready;
	logic o_pix_valid;
	rgb_lane_t o_pix_a;
	rgb_lane_t o_pix_b;
	rgb_lane_t o_pix_c;
	logic o_src_update;
	logic ld;
	logic gate_start_pulse;
	logic gate_shift_clock;
	logic gate_output_enable;
	int errors = 0;
	int check_count = 0;
	int req_n = 0;
	int pix_n = 0;
	int frames = 0;
	rgb_link_if link ();
	rgb_host_end u_rgb_host_end
	(
		.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_run(i_run),
		.i_pix_a(i_pix_a), .i_pix_b(i_pix_b), .i_pix_c(i_pix_c),
		.o_pixel_req(o_pixel_req), .o_frame_start(o_frame_start), .o_busy(o_busy),
		.link(link)
	);
	rgb_panel_end u_rgb_panel_end
	(
		.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_mode_sel(i_mode_sel), .link(link),
		.o_panel_ready(o_panel_ready), .o_pix_valid(o_pix_valid),
		.o_pix_a(o_pix_a), .o_pix_b(o_pix_b), .o_pix_c(o_pix_c),
		.o_src_update(o_src_update), .o_source_latch_pulse(ld),
		.o_gate_start_pulse(gate_start_pulse), .o_gate_shift_clock(gate_shift_clock), .o_gate_output_enable(gate_output_enable)
	);
	rgb_link_checker u_rgb_link_checker
	(
		.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .pixel_clock(link.pixel_clock),
		.hsync_in(link.hsync_in), .vsync_in(link.vsync_in),
		.data_enable_strobe(link.data_enable_strobe), .pixel_lane_a(link.pixel_lane_a),
		.pixel_lane_b(link.pixel_lane_b), .pixel_lane_c(link.pixel_lane_c),
		.o_src_update(o_src_update), .o_source_latch_pulse(ld),
		.o_gate_start_pulse(gate_start_pulse), .o_gate_shift_clock(gate_shift_clock), .o_gate_output_enable(gate_output_enable)
	);
	// lanes a and b always differ so a swap shows; c equals a for pixels 0-7 and b for 2040-2047
	function automatic logic [23:0] pat(int n);
		return {n[7:0], ~n[7:0], n[7:0] ^ n[10:3]};
	endfunction
	initial
	begin
		i_clk_sys = 1'b0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end
	// user side feeds each request; panel output must replay the same order
	always @(negedge i_clk_sys)
	begin
		if (o_pixel_req === 1'b1)
		begin
			{i_pix_a, i_pix_b, i_pix_c} <= pat(req_n);
			req_n <= req_n + 1;
		end
		if (o_pix_valid === 1'b1)
		begin
			`CHK("pixel", pat(pix_n), {o_pix_a, o_pix_b, o_pix_c})
			pix_n <= pix_n + 1;
		end
		if (o_frame_start === 1'b1)
			frames <= frames + 1;
	end
	task automatic final_report();
		if (errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic give_up();
		errors++;
		final_report();
	endtask
	// counts panel pixels up to the next hsync leading edge
	task automatic wait_line(output int npix, output logic vs);
		int k;
		logic prev;
		npix = 0;
		prev = link.hsync_in;
		for (k = 0; k < 3000; k++)
		begin
			@(negedge i_clk_sys);
			npix += (o_pix_valid === 1'b1);
			if (link.hsync_in === 1'b1 && prev === 1'b0)
				break;
			prev = link.hsync_in;
		end
		if (k == 3000)
			give_up();
		vs = link.vsync_in;
	endtask
	task automatic sc_reset();
		int k;
		`CHK("panel reset", 1'b0, link.reset_n)
		`CHK("pclk idle", 1'b0, link.pixel_clock)
		i_rst_n = 1'b1;
		for (k = 0; k < 1200 && link.reset_n !== 1'b1; k++)
			@(negedge i_clk_sys);
		if (k == 1200)
			give_up();
		`CHK("reset low long", 1'b1, k >= 1000)
		repeat (3) @(negedge i_clk_sys);
		`CHK("panel ready", 1'b1, o_panel_ready)
	endtask
	// sync mode: 23 blank lines from vsync, then a full line
	task automatic sc_sync_mode();
		int k;
		int npix;
		int blank;
		int vlines;
		logic vs;
		blank = 0;
		vlines = 0;
		for (k = 0; k < 5000 && link.vsync_in !== 1'b1; k++)
			@(negedge i_clk_sys);
		if (k == 5000)
			give_up();
		vs = 1'b1;
		for (k = 0; k < 23; k++)
		begin
			vlines += vs;
			wait_line(npix, vs);
			blank += npix;
		end
		`CHK("vsync lines", 10, vlines)
		`CHK("blank pixels", 0, blank)
		wait_line(npix, vs);
		`CHK("sync line pixels", 800, npix)
	endtask
	// enable mode from the next line on
	task automatic sc_de_mode();
		int npix;
		logic vs;
		i_mode_sel = 1'b1;
		repeat (2)
		begin
			wait_line(npix, vs);
			`CHK("de line pixels", 800, npix)
			`CHK("no early frame", 1'b0, vs)
		end
	endtask
	initial
	begin
		i_rst_n = 1'b0;
		i_run = 1'b1;
		i_mode_sel = 1'b0;
		repeat (5) @(negedge i_clk_sys);
		sc_reset();
		sc_sync_mode();
		sc_de_mode();
		`CHK("pixels total", 2400, pix_n)
		`CHK("frame starts", 1, frames)
		`CHK("busy", 1'b1, o_busy)
		final_report();
	end
endmodule // tb_top
`default_nettype wire
